// file: logic/ccr_pkg.sv
// Purpose: Shared constants and types for the calendar clock register access block.
// Assumes: Classic Wishbone slave with 32-bit data; registers hold 16 bits in the low lanes.
// Notes: Offsets are byte addresses of aligned words.
package ccr_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFF_CONFIG      = 5'h00;
	localparam logic [4:0] OFF_TIME_WIN    = 5'h04;
	localparam logic [4:0] OFF_ALARM_CFG   = 5'h08;
	localparam logic [4:0] OFF_ALARM_WIN   = 5'h0C;
	localparam logic [4:0] OFF_UNLOCK_KEY  = 5'h10;
	localparam logic [4:0] OFF_POWER_CTRL  = 5'h14;
	localparam logic [4:0] OFF_STATUS      = 5'h18;
	localparam int unsigned PTR_LSB        = 8;
	localparam int unsigned UNLOCK_BIT     = 13;
	localparam int unsigned ENABLE_BIT     = 15;
	localparam int unsigned SYNC_BIT       = 12;
	localparam logic [7:0]  KEY_FIRST      = 8'h55;
	localparam logic [7:0]  KEY_SECOND     = 8'hAA;
	localparam logic [1:0]  PTR_MIN_SEC    = 2'h0;
	localparam logic [1:0]  PTR_WD_HR      = 2'h1;
	localparam logic [1:0]  PTR_MON_DAY    = 2'h2;
	localparam logic [1:0]  PTR_YEAR       = 2'h3;
	localparam logic [1:0]  CLK_SECONDARY_CRYSTAL_OSC       = 2'h0;
	localparam logic [1:0]  CLK_LOW_POWER_RC_OSC       = 2'h1;
	localparam logic [1:0]  CLK_LINE50     = 2'h2;
	localparam logic [1:0]  CLK_LINE60     = 2'h3;
	localparam logic [15:0] CONFIG_RESET   = 16'h0000;
	localparam int unsigned TRIM_SECONDS   = 15;
	localparam int unsigned KEY_WINDOW_CYC = 1;

	typedef enum logic [1:0] {
		CCR_KEY_IDLE,
		CCR_KEY_GOT55,
		CCR_KEY_OPEN
	} ccr_key_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} ccr_pair_t;

	typedef struct packed {
		ccr_pair_t min_sec;
		ccr_pair_t wd_hr;
		ccr_pair_t mon_day;
		logic [7:0] year;
	} ccr_time_t;

	typedef struct packed {
		ccr_pair_t min_sec;
		ccr_pair_t wd_hr;
		ccr_pair_t mon_day;
	} ccr_alarm_t;
endpackage : ccr_pkg

// file: logic/ccr_regs.sv
// Purpose: Register access of a real-time clock: pointer windows, write lock, clock select, drift trim.
// Assumes: Counting and alarm matching sit outside and consume the values driven here.
// Notes: por_i resets every register, the configuration register included; rst_i resets everything but the configuration register.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns

module ccr_regs (
	// Clock and resets
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              por_i,
	// Wishbone slave
	input  wire logic                              cyc_i,
	input  wire logic                              stb_i,
	input  wire logic                              we_i,
	input  wire logic [ccr_pkg::ADDR_W-1:0]        adr_i,
	input  wire logic [3:0]                        sel_i,
	input  wire logic [31:0]                       dat_i,
	output logic      [31:0]                       dat_o,
	output logic                                   ack_o,
	// Status from the counter
	input  wire logic                              sync_set_i,
	// Values to the counting logic
	output ccr_pkg::ccr_time_t                     time_o,
	output ccr_pkg::ccr_alarm_t                    alarm_o,
	output logic                                   enable_o,
	output logic      [1:0]                        clk_sel_o,
	output logic signed [7:0]                      trim_o,
	output logic                                   trim_negative_o
);
	logic [15:0]          config_q;
	logic [15:0]          next_config;
	logic [15:0]          alarm_cfg_q;
	logic [15:0]          next_alarm_cfg;
	logic [1:0]           power_q;
	logic [1:0]           next_power;
	ccr_pkg::ccr_time_t   time_q;
	ccr_pkg::ccr_time_t   next_time;
	ccr_pkg::ccr_alarm_t  alarm_q;
	ccr_pkg::ccr_alarm_t  next_alarm;
	ccr_pkg::ccr_key_t    key_q;
	ccr_pkg::ccr_key_t    next_key;
	logic                 ack_q;
	logic [31:0]          rdata_q;
	logic [31:0]          next_rdata;
	logic                 req;
	logic                 wr;
	logic                 rd;
	logic [1:0]           tptr;
	logic [1:0]           aptr;
	logic                 unlocked;

	assign req      = cyc_i && stb_i && !ack_q;
	assign wr       = req && we_i;
	assign rd       = req && !we_i;
	assign tptr     = config_q[ccr_pkg::PTR_LSB+1:ccr_pkg::PTR_LSB];
	assign aptr     = alarm_cfg_q[ccr_pkg::PTR_LSB+1:ccr_pkg::PTR_LSB];
	assign unlocked = config_q[ccr_pkg::UNLOCK_BIT];

	function automatic logic [1:0] ptr_down(input logic [1:0] p);
		ptr_down = (p == ccr_pkg::PTR_MIN_SEC) ? ccr_pkg::PTR_MIN_SEC : p - 2'h1;
	endfunction : ptr_down

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv, input logic en);
		merge = en ? nv : old;
	endfunction : merge

	// Key sequence: OPEN lasts from the AA write until the next write of any kind, the window for setting the unlock bit.
	always_comb
	begin
		next_key = ccr_pkg::CCR_KEY_IDLE;
		unique case (key_q)
			ccr_pkg::CCR_KEY_IDLE:
			begin
				if (wr && adr_i == ccr_pkg::OFF_UNLOCK_KEY && sel_i[0] && dat_i[7:0] == ccr_pkg::KEY_FIRST)
					next_key = ccr_pkg::CCR_KEY_GOT55;
			end
			ccr_pkg::CCR_KEY_GOT55:
			begin
				if (!wr)
					next_key = ccr_pkg::CCR_KEY_GOT55;
				else if (adr_i == ccr_pkg::OFF_UNLOCK_KEY && sel_i[0] && dat_i[7:0] == ccr_pkg::KEY_SECOND)
					next_key = ccr_pkg::CCR_KEY_OPEN;
			end
			ccr_pkg::CCR_KEY_OPEN:
			begin
				if (!wr)
					next_key = ccr_pkg::CCR_KEY_OPEN;
			end
			default:
				next_key = ccr_pkg::CCR_KEY_IDLE;
		endcase
	end

	always_comb
	begin
		next_config    = config_q;
		next_alarm_cfg = alarm_cfg_q;
		next_power     = power_q;
		next_time      = time_q;
		next_alarm     = alarm_q;
		next_rdata     = 32'h0000_0000;
		if (wr)
		begin
			unique case (adr_i)
				ccr_pkg::OFF_CONFIG:
				begin
					if (sel_i[0])
						next_config[7:0] = dat_i[7:0];
					if (sel_i[1])
					begin
						next_config[9:8] = dat_i[9:8];
						if (dat_i[ccr_pkg::UNLOCK_BIT] == 1'b0)
							next_config[ccr_pkg::UNLOCK_BIT] = 1'b0;
						else if (key_q == ccr_pkg::CCR_KEY_OPEN)
							next_config[ccr_pkg::UNLOCK_BIT] = 1'b1;
						if (unlocked)
							next_config[ccr_pkg::ENABLE_BIT] = dat_i[ccr_pkg::ENABLE_BIT];
					end
				end
				ccr_pkg::OFF_ALARM_CFG:
				begin
					if (sel_i[0])
						next_alarm_cfg[7:0] = dat_i[7:0];
					if (sel_i[1])
						next_alarm_cfg[15:8] = dat_i[15:8];
				end
				ccr_pkg::OFF_POWER_CTRL:
				begin
					if (sel_i[0])
						next_power = dat_i[1:0];
				end
				ccr_pkg::OFF_TIME_WIN:
				begin
					if (unlocked)
					begin
						unique case (tptr)
							ccr_pkg::PTR_MIN_SEC:
							begin
								next_time.min_sec.hi = merge(time_q.min_sec.hi, dat_i[15:8], sel_i[1]);
								next_time.min_sec.lo = merge(time_q.min_sec.lo, dat_i[7:0], sel_i[0]);
								if (sel_i[0])
									next_config[ccr_pkg::SYNC_BIT] = 1'b0;
							end
							ccr_pkg::PTR_WD_HR:
							begin
								next_time.wd_hr.hi = merge(time_q.wd_hr.hi, dat_i[15:8], sel_i[1]);
								next_time.wd_hr.lo = merge(time_q.wd_hr.lo, dat_i[7:0], sel_i[0]);
							end
							ccr_pkg::PTR_MON_DAY:
							begin
								next_time.mon_day.hi = merge(time_q.mon_day.hi, dat_i[15:8], sel_i[1]);
								next_time.mon_day.lo = merge(time_q.mon_day.lo, dat_i[7:0], sel_i[0]);
							end
							ccr_pkg::PTR_YEAR:
							begin
								next_time.year = merge(time_q.year, dat_i[7:0], sel_i[0]);
							end
						endcase
						if (sel_i[1])
							next_config[9:8] = ptr_down(tptr);
					end
				end
				ccr_pkg::OFF_ALARM_WIN:
				begin
					unique case (aptr)
						ccr_pkg::PTR_MIN_SEC:
						begin
							next_alarm.min_sec.hi = merge(alarm_q.min_sec.hi, dat_i[15:8], sel_i[1]);
							next_alarm.min_sec.lo = merge(alarm_q.min_sec.lo, dat_i[7:0], sel_i[0]);
						end
						ccr_pkg::PTR_WD_HR:
						begin
							next_alarm.wd_hr.hi = merge(alarm_q.wd_hr.hi, dat_i[15:8], sel_i[1]);
							next_alarm.wd_hr.lo = merge(alarm_q.wd_hr.lo, dat_i[7:0], sel_i[0]);
						end
						ccr_pkg::PTR_MON_DAY:
						begin
							next_alarm.mon_day.hi = merge(alarm_q.mon_day.hi, dat_i[15:8], sel_i[1]);
							next_alarm.mon_day.lo = merge(alarm_q.mon_day.lo, dat_i[7:0], sel_i[0]);
						end
						ccr_pkg::PTR_YEAR:
						begin
							next_alarm = alarm_q;
						end
					endcase
					if (sel_i[1])
						next_alarm_cfg[9:8] = ptr_down(aptr);
				end
				default:
				begin
					next_power = power_q;
				end
			endcase
		end
		else if (rd)
		begin
			unique case (adr_i)
				ccr_pkg::OFF_CONFIG:
					next_rdata = {16'h0000, config_q};
				ccr_pkg::OFF_ALARM_CFG:
					next_rdata = {16'h0000, alarm_cfg_q};
				ccr_pkg::OFF_POWER_CTRL:
					next_rdata = {30'h0000_0000, power_q};
				ccr_pkg::OFF_UNLOCK_KEY:
					next_rdata = 32'h0000_0000;
				ccr_pkg::OFF_STATUS:
					next_rdata = {29'h0000_0000, key_q == ccr_pkg::CCR_KEY_OPEN, unlocked,
						config_q[ccr_pkg::SYNC_BIT]};
				ccr_pkg::OFF_TIME_WIN:
				begin
					unique case (tptr)
						ccr_pkg::PTR_MIN_SEC: next_rdata = {16'h0000, time_q.min_sec};
						ccr_pkg::PTR_WD_HR:   next_rdata = {16'h0000, time_q.wd_hr};
						ccr_pkg::PTR_MON_DAY: next_rdata = {16'h0000, time_q.mon_day};
						ccr_pkg::PTR_YEAR:    next_rdata = {24'h00_0000, time_q.year};
					endcase
					next_config[9:8] = ptr_down(tptr);
				end
				ccr_pkg::OFF_ALARM_WIN:
				begin
					unique case (aptr)
						ccr_pkg::PTR_MIN_SEC: next_rdata = {16'h0000, alarm_q.min_sec};
						ccr_pkg::PTR_WD_HR:   next_rdata = {16'h0000, alarm_q.wd_hr};
						ccr_pkg::PTR_MON_DAY: next_rdata = {16'h0000, alarm_q.mon_day};
						ccr_pkg::PTR_YEAR:    next_rdata = 32'h0000_0000;
					endcase
					next_alarm_cfg[9:8] = ptr_down(aptr);
				end
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
		// Set wins over a clearing write in the same cycle.
		if (sync_set_i)
			next_config[ccr_pkg::SYNC_BIT] = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (por_i)
			config_q <= ccr_pkg::CONFIG_RESET;
		else
			config_q <= next_config;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || por_i)
		begin
			alarm_cfg_q <= 16'h0000;
			power_q     <= ccr_pkg::CLK_SECONDARY_CRYSTAL_OSC;
			time_q      <= '0;
			alarm_q     <= '0;
			key_q       <= ccr_pkg::CCR_KEY_IDLE;
			ack_q       <= 1'b0;
			rdata_q     <= 32'h0000_0000;
		end
		else
		begin
			alarm_cfg_q <= next_alarm_cfg;
			power_q     <= next_power;
			time_q      <= next_time;
			alarm_q     <= next_alarm;
			key_q       <= next_key;
			ack_q       <= req;
			rdata_q     <= next_rdata;
		end
	end

	assign ack_o           = ack_q;
	assign dat_o           = rdata_q;
	assign time_o          = time_q;
	assign alarm_o         = alarm_q;
	assign enable_o        = config_q[ccr_pkg::ENABLE_BIT];
	assign clk_sel_o       = power_q;
	assign trim_o          = config_q[7:0];
	assign trim_negative_o = config_q[7];
endmodule : ccr_regs

// file: testbench/ccr_regs_sva.sv
// Purpose: Port-level assertions for the calendar clock register block.
// Assumes: A register write lands at the edge that raises ack.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ns
module ccr_regs_sva (
	// Clock and resets
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                por_i,
	// Wishbone slave
	input wire logic                cyc_i,
	input wire logic                stb_i,
	input wire logic                we_i,
	input wire logic [4:0]          adr_i,
	input wire logic [31:0]         dat_o,
	input wire logic                ack_o,
	// Register outputs
	input wire ccr_pkg::ccr_time_t  time_o,
	input wire ccr_pkg::ccr_alarm_t alarm_o,
	input wire logic                enable_o,
	input wire logic [1:0]          clk_sel_o,
	input wire logic signed [7:0]   trim_o,
	input wire logic                trim_negative_o
);
	logic wr_take;
	assign wr_take = cyc_i && stb_i && we_i && !ack_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);
	sequence req_s; cyc_i && stb_i && !ack_o; endsequence
	sequence pulse_s; ack_o ##1 !ack_o; endsequence
	ack_pulse_a: assert property (req_s |=> pulse_s) else $error("ack not a single pulse");
	idle_data_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data without ack");
	trim_sign_a: assert property (trim_negative_o == trim_o[7]) else $error("trim sign wrong");
	clk_sel_a: assert property (!$stable(clk_sel_o) |->
		$past(wr_take && adr_i == ccr_pkg::OFF_POWER_CTRL)) else $error("clock select changed unasked");
	time_write_a: assert property (!$stable(time_o) |->
		$past(wr_take && adr_i == ccr_pkg::OFF_TIME_WIN)) else $error("time changed unasked");
	alarm_write_a: assert property (!$stable(alarm_o) |->
		$past(wr_take && adr_i == ccr_pkg::OFF_ALARM_WIN)) else $error("alarm changed unasked");
	enable_write_a: assert property (!$stable(enable_o) |->
		$past(wr_take && adr_i == ccr_pkg::OFF_CONFIG)) else $error("enable changed unasked");
	config_keep_a: assert property (disable iff (por_i) rst_i |=> $stable(trim_o))
		else $error("trim lost on plain reset");
endmodule : ccr_regs_sva

// file: testbench/test_ccr_regs.sv
// Purpose: Directed Wishbone tests of the calendar clock register block.
// Assumes: 50 MHz clock; a write lands at the edge that raises ack.
// Notes: Reads return the whole 16-bit pair whatever the byte enables.
`timescale 1ns/1ns
module test_ccr_regs;
	logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, sync_set_i, ack_o, enable_o, trim_negative_o;
	logic [4:0]          adr_i;
	logic [3:0]          sel_i;
	logic [31:0]         dat_i, dat_o, rd;
	logic [1:0]          clk_sel_o;
	logic signed [7:0]   trim_o;
	ccr_pkg::ccr_time_t  time_o;
	ccr_pkg::ccr_alarm_t alarm_o;
	logic [15:0]         tv [0:4] = '{16'h0011, 16'h2122, 16'h3132, 16'h4142, 16'h5152};
	int                  n_mismatch = 0, n_compared = 0, cycles = 0;

	ccr_regs u_ccr_regs (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sync_set_i(sync_set_i),
		.time_o(time_o), .alarm_o(alarm_o), .enable_o(enable_o), .clk_sel_o(clk_sel_o), .trim_o(trim_o),
		.trim_negative_o(trim_negative_o));

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		if (seen !== exp)
			n_mismatch++;
	endtask : check

	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 16'h0, d};
		@(posedge clk_i iff ack_o === 1'b1);
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 4'h3);
	endtask : wr

	task automatic rc(input logic [4:0] a, input logic [15:0] e, input logic [3:0] s);
		bus(1'b0, a, 16'h0, s);
		check(rd, {16'h0, e});
	endtask : rc

	task automatic reset(input logic p);
		@(posedge clk_i);
		{rst_i, por_i} <= {1'b1, p};
		repeat (3) @(posedge clk_i);
		{rst_i, por_i} <= 2'b00;
	endtask : reset

	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, sync_set_i} = '0;
		{rst_i, por_i} = 2'b11;
		reset(1'b1);
		rc(ccr_pkg::OFF_CONFIG, ccr_pkg::CONFIG_RESET, 4'h3);
		wr(ccr_pkg::OFF_CONFIG, 16'h827F);
		check({enable_o, trim_negative_o, trim_o}, 10'h07F);
		wr(ccr_pkg::OFF_CONFIG, 16'h0280);
		check({enable_o, trim_negative_o, trim_o}, 10'h180);
		wr(ccr_pkg::OFF_TIME_WIN, 16'h1234);
		check(time_o, 56'h0);
		// A foreign write between the key and the unlock closes the window.
		wr(ccr_pkg::OFF_UNLOCK_KEY, {8'h00, ccr_pkg::KEY_FIRST});
		wr(ccr_pkg::OFF_UNLOCK_KEY, {8'h00, ccr_pkg::KEY_SECOND});
		wr(ccr_pkg::OFF_ALARM_CFG, 16'h0300);
		wr(ccr_pkg::OFF_CONFIG, 16'hA300);
		rc(ccr_pkg::OFF_STATUS, 16'h0000, 4'h1);
		wr(ccr_pkg::OFF_UNLOCK_KEY, {8'h00, ccr_pkg::KEY_FIRST});
		wr(ccr_pkg::OFF_UNLOCK_KEY, {8'h00, ccr_pkg::KEY_SECOND});
		rc(ccr_pkg::OFF_STATUS, 16'h0004, 4'h1);
		sync_set_i <= 1'b1;
		wr(ccr_pkg::OFF_CONFIG, 16'hA300);
		sync_set_i <= 1'b0;
		rc(ccr_pkg::OFF_STATUS, 16'h0003, 4'h1);
		check(enable_o, 1'b0);
		wr(ccr_pkg::OFF_CONFIG, 16'hA300);
		check(enable_o, 1'b1);
		foreach (tv[i])
			wr(ccr_pkg::OFF_TIME_WIN, tv[i]);
		check(time_o, {tv[4], tv[2], tv[1], tv[0][7:0]});
		rc(ccr_pkg::OFF_STATUS, 16'h0002, 4'h1);
		wr(ccr_pkg::OFF_CONFIG, 16'h8300);
		wr(ccr_pkg::OFF_TIME_WIN, 16'hFFFF);
		check(enable_o, 1'b1);
		rc(ccr_pkg::OFF_TIME_WIN, tv[0], 4'h1);
		bus(1'b0, ccr_pkg::OFF_TIME_WIN, 16'h0, 4'h2);
		rc(ccr_pkg::OFF_TIME_WIN, tv[2], 4'h3);
		rc(ccr_pkg::OFF_TIME_WIN, tv[4], 4'h3);
		wr(ccr_pkg::OFF_ALARM_WIN, 16'hDEAD);
		for (int i = 1; i < 5; i++)
			wr(ccr_pkg::OFF_ALARM_WIN, tv[i]);
		check(alarm_o, {tv[4], tv[2], tv[1]});
		rc(ccr_pkg::OFF_ALARM_CFG, 16'h0000, 4'h3);
		wr(ccr_pkg::OFF_ALARM_CFG, 16'h0300);
		rc(ccr_pkg::OFF_ALARM_WIN, 16'h0000, 4'h2);
		rc(ccr_pkg::OFF_ALARM_WIN, tv[1], 4'h3);
		for (int i = 0; i < 4; i++)
		begin
			wr(ccr_pkg::OFF_POWER_CTRL, i[15:0]);
			check(clk_sel_o, i[1:0]);
		end
		wr(5'h1C, 16'hFFFF);
		rc(5'h1C, 16'h0000, 4'h3);
		wr(ccr_pkg::OFF_CONFIG, 16'h0355);
		reset(1'b0);
		rc(ccr_pkg::OFF_CONFIG, 16'h8355, 4'h3);
		tally_and_finish();
	end
endmodule : test_ccr_regs

bind ccr_regs ccr_regs_sva u_ccr_regs_sva (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .time_o(time_o),
	.alarm_o(alarm_o), .enable_o(enable_o), .clk_sel_o(clk_sel_o), .trim_o(trim_o),
	.trim_negative_o(trim_negative_o));
